// File: urx_defines.vh
// Purpose: Constants for the receive buffer, status and error block.
// Assumes: 50 MHz system clock; sample tick supplied from outside.
// Notes:   Operation
`ifndef URX_DEFINES_VH
`define URX_DEFINES_VH
`define URX_DEPTH       2
`define URX_ENTRY_W     12
`define URX_F_NINTH     8
`define URX_F_FE        9
`define URX_F_DOR       10
`define URX_F_UPE       11
`define URX_OS_NORMAL   5'h10
`define URX_OS_DOUBLE   5'h08
`define URX_VOTE_NORMAL 5'h08
`define URX_VOTE_DOUBLE 5'h04
`define URX_SIZE_NINE   3'h7
`endif

// File: urx_shift.v
// Purpose: Serial receive shift register with start-bit vote and parity.
// Assumes: sample_tick pulses at 16x (or 8x) the bit rate; sync_tick
//          pulses once per bit on the external clock edge when synchronous.
// Notes:   Produces one frame word per received frame.
`timescale 1ns/10ps
`include "urx_defines.vh"
module urx_shift (
  input  wire        clk,
  input  wire        nrst,
  input  wire        enable,
  input  wire        rx_pin,
  input  wire        sample_tick,
  input  wire        sync_mode,
  input  wire        sync_tick,
  input  wire        double_speed_sel,
  input  wire [2:0]  char_size_sel,
  input  wire        parity_enable_bit,
  input  wire        parity_odd_sel,
  output reg         start_seen,
  output reg         frame_done,
  output reg  [11:0] frame_word
);
  localparam ST_IDLE  = 3'b001;
  localparam ST_START = 3'b010;
  localparam ST_BITS  = 3'b100;

  reg [2:0] state;      // One-hot receiver state.
  reg [4:0] sample_cnt; // Oversample counter inside a bit.
  reg [2:0] votes;      // Three centre samples of the current bit.
  reg [3:0] bit_idx;    // Bit index after the start bit.
  reg [8:0] data;       // Collected data bits, LSB first.
  reg       par_bit;    // Received parity bit.

  wire [4:0] os   = double_speed_sel ? `URX_OS_DOUBLE : `URX_OS_NORMAL;
  wire [4:0] vote = double_speed_sel ? `URX_VOTE_DOUBLE : `URX_VOTE_NORMAL;
  wire [3:0] nbits = (char_size_sel == `URX_SIZE_NINE) ? 4'h9 :
                     ({2'b00, char_size_sel[1:0]} + 4'h5);
  wire [3:0] last_idx = nbits + {3'b000, parity_enable_bit};

  // Majority of three samples.
  function maj3;
    input [2:0] s;
    begin
      maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    end
  endfunction

  // Resolved value of a bit: pin directly when synchronous.
  wire bit_val = sync_mode ? rx_pin : maj3(votes);
  wire bit_end = sync_mode ? sync_tick :
                 (sample_tick && sample_cnt == os);
  // Even parity when the odd select is zero, odd parity when it is one.
  wire calc_par = ^(data & ((9'h001 << nbits) - 9'h001)) ^
                  parity_odd_sel;

  // Receive sequencer; disable returns it to idle at once.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_IDLE;
      sample_cnt <= 5'h00;
      votes      <= 3'h0;
      bit_idx    <= 4'h0;
      data       <= 9'h000;
      par_bit    <= 1'b0;
      start_seen <= 1'b0;
      frame_done <= 1'b0;
      frame_word <= 12'h000;
    end else begin
      start_seen <= 1'b0;
      frame_done <= 1'b0;
      if (!enable) begin
        state <= ST_IDLE;
      end else begin
        case (state)
          ST_IDLE: begin
            // The tick that sees the first low level is sample one, so
            // the next tick is sample two and the vote hits 8 to 10 (4 to 6 at double speed).
            sample_cnt <= 5'h02;
            votes      <= 3'h0;
            if (sync_mode ? (sync_tick && !rx_pin) :
                (sample_tick && !rx_pin)) begin
              if (sync_mode) begin
                state      <= ST_BITS;
                bit_idx    <= 4'h0;
                start_seen <= 1'b1;
              end else begin
                state <= ST_START;
              end
            end
          end
          ST_START: begin
            if (sample_tick) begin
              sample_cnt <= sample_cnt + 5'h01;
              if (sample_cnt >= vote && sample_cnt <= vote + 5'h02)
                votes <= {votes[1:0], rx_pin};
              if (sample_cnt == vote + 5'h02) begin
                if (maj3({votes[1:0], rx_pin})) begin
                  state <= ST_IDLE;
                end else begin
                  start_seen <= 1'b1;
                end
              end
              if (sample_cnt == os) begin
                state      <= ST_BITS;
                sample_cnt <= 5'h01;
                bit_idx    <= 4'h0;
              end
            end
          end
          ST_BITS: begin
            if (sample_tick && !sync_mode) begin
              sample_cnt <= (sample_cnt == os) ? 5'h01 :
                            sample_cnt + 5'h01;
              if (sample_cnt >= vote && sample_cnt <= vote + 5'h02)
                votes <= {votes[1:0], rx_pin};
            end
            if (bit_end) begin
              bit_idx <= bit_idx + 4'h1;
              if (bit_idx < nbits) begin
                data[bit_idx] <= bit_val;
              end else if (bit_idx < last_idx) begin
                par_bit <= bit_val;
              end else begin
                // First stop bit ends the frame; a second is ignored.
                state      <= ST_IDLE;
                frame_done <= 1'b1;
                frame_word[7:0] <= data[7:0] &
                  ((char_size_sel == `URX_SIZE_NINE) ? 8'hFF :
                   (8'hFF >> (4'h8 - nbits)));
                // A stale ninth bit from an earlier frame must not leak.
                frame_word[`URX_F_NINTH] <= data[8] &
                  (char_size_sel == `URX_SIZE_NINE);
                frame_word[`URX_F_FE]    <= ~bit_val;
                frame_word[`URX_F_DOR]   <= 1'b0;
                frame_word[`URX_F_UPE]   <= parity_enable_bit &
                                            (calc_par != par_bit);
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// File: urx_top.v
// Purpose: Receive buffer, status flags and error logic of a serial port.
// Assumes: All inputs synchronous to clk; data port read is a pulse.
// Notes:   Two-entry buffer plus shift register; overrun tagged on entry.
`timescale 1ns/10ps
`include "urx_defines.vh"
module urx_top #(
  parameter DEPTH = `URX_DEPTH
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        rx_pin,
  input  wire        sample_tick,
  input  wire        sync_mode,
  input  wire        ext_transfer_clock,
  input  wire        rx_enable_bit,
  input  wire        rx_complete_irq_en,
  input  wire        global_irq_en,
  input  wire        double_speed_sel,
  input  wire [2:0]  char_size_sel,
  input  wire        stop_bit_sel,
  input  wire        parity_enable_bit,
  input  wire        parity_odd_sel,
  input  wire        rx_data_read,
  output reg  [7:0]  rx_data_port,
  output reg         rx_ninth_bit,
  output reg         frame_err_flag,
  output reg         overrun_flag,
  output reg         parity_err_flag,
  output reg         rx_complete_flag,
  output reg         rx_complete_irq,
  output reg         rx_pin_owned
);
  reg [11:0] mem [0:DEPTH-1]; // Buffer entries, one word per frame.
  reg        rd_ptr;          // Read slot.
  reg        wr_ptr;          // Write slot.
  reg [1:0]  count;           // Entries held.
  reg        held;            // Frame waiting in the shift register.
  reg [11:0] held_word;       // Word parked while buffer is full.
  reg        lost;            // A frame was dropped since last store.
  reg        xck_d;           // Previous external clock level.

  wire        start_seen;
  wire        frame_done;
  wire [11:0] frame_word;
  wire        sync_tick = ext_transfer_clock & ~xck_d;

  // Receiver core; stop_bit_sel is not used by it.
  urx_shift u_shift (
    .clk               (clk),
    .nrst              (nrst),
    .enable            (rx_enable_bit),
    .rx_pin            (rx_pin),
    .sample_tick       (sample_tick),
    .sync_mode         (sync_mode),
    .sync_tick         (sync_tick),
    .double_speed_sel  (double_speed_sel),
    .char_size_sel     (char_size_sel),
    .parity_enable_bit (parity_enable_bit),
    .parity_odd_sel    (parity_odd_sel),
    .start_seen        (start_seen),
    .frame_done        (frame_done),
    .frame_word        (frame_word)
  );

  wire full = (count == DEPTH);
  wire pop  = rx_data_read && (count != 2'b00);
  // A frame to store: freshly done or parked, and room after the pop.
  wire new_in  = held ? 1'b0 : frame_done;
  wire src_val = held | new_in;
  wire push    = src_val && (!full || pop);
  wire [11:0] src_word = held ? held_word : frame_word;
  wire [1:0]  next_count = count + {1'b0, push} - {1'b0, pop};
  wire        next_rd    = pop ? ~rd_ptr : rd_ptr;

  // Buffer pointers, park slot and overrun tracking.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_ptr    <= 1'b0;
      wr_ptr    <= 1'b0;
      count     <= 2'b00;
      held      <= 1'b0;
      held_word <= 12'h000;
      lost      <= 1'b0;
      xck_d     <= 1'b0;
    end else begin
      xck_d <= ext_transfer_clock;
      if (!rx_enable_bit) begin
        // Flush everything at once.
        rd_ptr <= 1'b0;
        wr_ptr <= 1'b0;
        count  <= 2'b00;
        held   <= 1'b0;
        lost   <= 1'b0;
      end else begin
        rd_ptr <= next_rd;
        count  <= next_count;
        if (push) begin
          // Whole word written at once, overrun marked on entry.
          mem[wr_ptr] <= {src_word[11], lost, src_word[9:0]};
          wr_ptr      <= ~wr_ptr;
          held        <= 1'b0;
          lost        <= 1'b0;
        end else if (new_in) begin
          held      <= 1'b1;
          held_word <= frame_word;
        end
        // Full, one parked, new start: the parked frame is lost.
        if (full && held && start_seen && !pop) begin
          held <= 1'b0;
          lost <= 1'b1;
        end
      end
    end
  end

  wire [11:0] head = mem[next_rd];

  // Visible outputs come from registers updated each cycle.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_data_port     <= 8'h00;
      rx_ninth_bit     <= 1'b0;
      frame_err_flag   <= 1'b0;
      overrun_flag     <= 1'b0;
      parity_err_flag  <= 1'b0;
      rx_complete_flag <= 1'b0;
      rx_complete_irq  <= 1'b0;
      rx_pin_owned     <= 1'b0;
    end else begin
      rx_pin_owned <= rx_enable_bit;
      if (!rx_enable_bit || next_count == 2'b00) begin
        rx_data_port     <= 8'h00;
        rx_ninth_bit     <= 1'b0;
        frame_err_flag   <= 1'b0;
        overrun_flag     <= 1'b0;
        parity_err_flag  <= 1'b0;
        rx_complete_flag <= 1'b0;
        rx_complete_irq  <= 1'b0;
      end else begin
        // Head stays until a read; no write path exists to the flags.
        rx_data_port     <= (count == 2'b00 || (pop && count == 2'b01)) ?
                            src_word[7:0] : head[7:0];
        rx_ninth_bit     <= (count == 2'b00 || (pop && count == 2'b01)) ?
                            src_word[`URX_F_NINTH] : head[`URX_F_NINTH];
        frame_err_flag   <= (count == 2'b00 || (pop && count == 2'b01)) ?
                            src_word[`URX_F_FE] : head[`URX_F_FE];
        overrun_flag     <= (count == 2'b00 || (pop && count == 2'b01)) ?
                            lost : head[`URX_F_DOR];
        parity_err_flag  <= (count == 2'b00 || (pop && count == 2'b01)) ?
                            src_word[`URX_F_UPE] :
                            head[`URX_F_UPE];
        rx_complete_flag <= 1'b1;
        rx_complete_irq  <= rx_complete_irq_en & global_irq_en;
      end
    end
  end
endmodule

// File: urx_chk.sv
// Purpose: Port checks for the receive buffer block.
// Assumes: One clock; nrst is asynchronous and active low.
// Notes:   Bound to urx_top after the module.
`timescale 1ns/10ps
module urx_chk #(
  parameter DEPTH = 2
) (
  input wire       clk,
  input wire       nrst,
  input wire       rx_enable_bit,
  input wire       rx_complete_irq_en,
  input wire       global_irq_en,
  input wire       parity_enable_bit,
  input wire       rx_data_read,
  input wire [7:0] rx_data_port,
  input wire       rx_ninth_bit,
  input wire       frame_err_flag,
  input wire       overrun_flag,
  input wire       parity_err_flag,
  input wire       rx_complete_flag,
  input wire       rx_complete_irq,
  input wire       rx_pin_owned
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // An entry waits with no read and no flush.
  sequence s_hold; rx_complete_flag && !rx_data_read && rx_enable_bit;
  endsequence
  // The request is pending and enabled for two cycles.
  sequence s_ask;
    (rx_complete_flag && rx_complete_irq_en && global_irq_en)[*2];
  endsequence
  property p_flag_hold; s_hold |=> rx_complete_flag; endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_head_hold; s_hold |=> $stable({rx_data_port, rx_ninth_bit,
    frame_err_flag, overrun_flag, parity_err_flag}); endproperty
  a_head_hold: assert property (p_head_hold) else $error("head moved");
  property p_irq_on; s_ask |-> rx_complete_irq; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_irq_off; (!rx_complete_flag)[*2] |-> !rx_complete_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("stray irq");
  property p_flush; !rx_enable_bit |=> !rx_complete_flag; endproperty
  a_flush: assert property (p_flush) else $error("no flush");
  property p_take_pin; $rose(rx_enable_bit) |=> rx_pin_owned; endproperty
  a_take_pin: assert property (p_take_pin) else $error("pin not taken");
  property p_free_pin; $fell(rx_enable_bit) |=> !rx_pin_owned; endproperty
  a_free_pin: assert property (p_free_pin) else $error("pin kept");
  property p_par_off; !parity_enable_bit |-> !parity_err_flag; endproperty
  a_par_off: assert property (p_par_off) else $error("parity flag");
endmodule
bind urx_top urx_chk #(.DEPTH(DEPTH)) i_chk (.clk, .nrst, .rx_enable_bit,
  .rx_complete_irq_en, .global_irq_en, .parity_enable_bit, .rx_data_read,
  .rx_data_port, .rx_ninth_bit, .frame_err_flag, .overrun_flag,
  .parity_err_flag, .rx_complete_flag, .rx_complete_irq, .rx_pin_owned);

// File: urx_tx_model.sv
// Purpose: Remote transmitter driving the serial receive line.
// Assumes: Bit length is given in sample ticks on each call.
// Notes:   The line idles high between frames.
`timescale 1ns/10ps
module urx_tx_model (
  input  wire clk,
  input  wire sample_tick,
  output reg  rx_pin
);
  initial rx_pin = 1'h1;
  // Holds the line for n sample ticks, then steps off the edge.
  task automatic ticks(input int n);
    repeat (n) @(posedge clk iff sample_tick);
    #1;
  endtask
  // Start, data LSB first, optional parity, one stop bit, one idle bit.
  task automatic send(input [8:0] d, input int nb,
                      input bit pe, odd, flip, stp, input int tpb);
    bit p;
    p = odd ^ flip;
    rx_pin = 1'h0;
    ticks(tpb);
    for (int i = 0; i < nb; i++) begin
      rx_pin = d[i];
      p = p ^ d[i];
      ticks(tpb);
    end
    if (pe) begin
      rx_pin = p;
      ticks(tpb);
    end
    rx_pin = stp;
    ticks(tpb);
    rx_pin = 1'h1;
    ticks(tpb);
  endtask
  // A short low pulse, then idle long enough for a false frame to land.
  task automatic glitch(input int n, input int tpb);
    rx_pin = 1'h0;
    ticks(n);
    rx_pin = 1'h1;
    ticks(12 * tpb);
  endtask
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the receive buffer block.
// Assumes: Sample tick on every second clock, so a bit is 32 clocks (16 at double speed).
// Notes:   Synchronous mode is exercised by t_sync.
`timescale 1ns/10ps
module tb_top;
  reg         clk = 1'h0, nrst = 1'h0, sample_tick = 1'h0;
  reg         sync_mode = 1'h0, ext_transfer_clock = 1'h0;
  reg         rx_enable_bit = 1'h0, rx_complete_irq_en = 1'h0;
  reg         global_irq_en = 1'h0, double_speed_sel = 1'h0;
  reg         stop_bit_sel = 1'h0, parity_enable_bit = 1'h0;
  reg         parity_odd_sel = 1'h0, rx_data_read = 1'h0;
  reg  [2:0]  char_size_sel = 3'h3;
  wire [7:0]  rx_data_port;
  wire        rx_ninth_bit, frame_err_flag, overrun_flag, parity_err_flag;
  wire        rx_complete_flag, rx_complete_irq, rx_pin_owned, rx_pin;
  int         error_cnt = 0, n_checks = 0;
  // Flag and head as {flag, upe, dor, fe, ninth, data}.
  wire [12:0] head = {rx_complete_flag, parity_err_flag, overrun_flag,
                      frame_err_flag, rx_ninth_bit, rx_data_port};
  urx_top i_dut (.clk, .nrst, .rx_pin, .sample_tick, .sync_mode,
    .ext_transfer_clock, .rx_enable_bit, .rx_complete_irq_en, .global_irq_en,
    .double_speed_sel, .char_size_sel, .stop_bit_sel, .parity_enable_bit,
    .parity_odd_sel, .rx_data_read, .rx_data_port, .rx_ninth_bit,
    .frame_err_flag, .overrun_flag, .parity_err_flag, .rx_complete_flag,
    .rx_complete_irq, .rx_pin_owned);
  urx_tx_model i_tx (.clk, .sample_tick, .rx_pin);
  // Clock of 20 ns and a sample tick on every second rising edge.
  always #10 clk = ~clk;
  always @(posedge clk) #1 sample_tick = ~sample_tick;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input [12:0] seen, input [12:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Expected head of a waiting entry with error bits {upe, dor, fe}.
  function automatic [12:0] ex(input [2:0] err, input [8:0] d);
    ex = {1'h1, err, d};
  endfunction
  // Judges status and ninth bit first, then pops with one read pulse.
  task automatic rd(input [12:0] e);
    chk("head", head, e);
    rx_data_read = 1'h1;
    cyc(1);
    rx_data_read = 1'h0;
    cyc(2);
  endtask
  // One frame with the current settings and a good stop bit.
  task automatic tx(input [8:0] d, input int nb);
    i_tx.send(d, nb, parity_enable_bit, parity_odd_sel, 1'h0, 1'h1,
              double_speed_sel ? 8 : 16);
    cyc(3);
  endtask
  task automatic t_basic;
    rx_complete_irq_en = 1'h1;
    tx(9'h0A5, 8);
    chk("irq_masked", 13'(rx_complete_irq), 13'h0);
    global_irq_en = 1'h1;
    cyc(8);
    chk("irq_held", 13'(rx_complete_irq), 13'h1);
    rd(ex(3'h0, 9'h0A5));
    chk("empty", head, 13'h0);
  endtask
  task automatic t_sizes;
    int sz[5] = '{0, 1, 2, 3, 7};
    int nb;
    foreach (sz[i]) begin
      char_size_sel = sz[i][2:0];
      nb = (sz[i] == 7) ? 9 : sz[i] + 5;
      tx(9'h1DB, nb);
      rd(ex(3'h0, 9'h1DB & 9'((1 << nb) - 1)));
    end
    char_size_sel = 3'h3;
  endtask
  task automatic t_parity;
    parity_enable_bit = 1'h1;
    for (int k = 0; k < 4; k++) begin
      parity_odd_sel = k[1];
      i_tx.send(9'h096, 8, 1'h1, k[1], k[0], 1'h1, 16);
      cyc(3);
      rd(ex({k[0], 2'h0}, 9'h096));
    end
    parity_enable_bit = 1'h0;
    tx(9'h096, 8);
    rd(ex(3'h0, 9'h096));
  endtask
  task automatic t_frame;
    stop_bit_sel = 1'h1;
    i_tx.send(9'h03C, 8, 1'h0, 1'h0, 1'h0, 1'h0, 16);
    tx(9'h0C3, 8);
    rd(ex(3'h1, 9'h03C));
    rd(ex(3'h0, 9'h0C3));
    stop_bit_sel = 1'h0;
  endtask
  task automatic t_overrun;
    tx(9'h011, 8);
    tx(9'h022, 8);
    tx(9'h033, 8);
    tx(9'h044, 8);
    rd(ex(3'h0, 9'h011));
    rd(ex(3'h0, 9'h022));
    rd(ex(3'h2, 9'h044));
    chk("lost", head, 13'h0);
    tx(9'h055, 8);
    rd(ex(3'h0, 9'h055));
  endtask
  task automatic t_flush;
    tx(9'h066, 8);
    tx(9'h077, 8);
    fork
      i_tx.send(9'h088, 8, 1'h0, 1'h0, 1'h0, 1'h1, 16);
      begin
        cyc(100);
        rx_enable_bit = 1'h0;
        cyc(2);
        chk("flushed", head, 13'h0);
        chk("pin_free", 13'(rx_pin_owned), 13'h0);
      end
    join
    rx_enable_bit = 1'h1;
    cyc(3);
    chk("aborted", head, 13'h0);
    tx(9'h099, 8);
    tx(9'h0AA, 8);
    rd(ex(3'h0, 9'h099));
    rd(ex(3'h0, 9'h0AA));
    chk("drained", head, 13'h0);
  endtask
  task automatic t_noise;
    i_tx.glitch(6, 16);
    chk("noise", head, 13'h0);
    double_speed_sel = 1'h1;
    i_tx.glitch(3, 8);
    chk("noise2x", head, 13'h0);
    tx(9'h05A, 8);
    rd(ex(3'h0, 9'h05A));
    double_speed_sel = 1'h0;
  endtask
  // Synchronous frame: each bit is clocked in on the transfer clock.
  task automatic t_sync;
    bit [9:0] fr;
    fr = {1'h1, 8'hC6, 1'h0};
    sync_mode = 1'h1;
    for (int i = 0; i < 10; i++) begin
      i_tx.rx_pin = fr[i];
      cyc(2);
      ext_transfer_clock = 1'h1;
      cyc(2);
      ext_transfer_clock = 1'h0;
    end
    i_tx.rx_pin = 1'h1;
    cyc(3);
    sync_mode = 1'h0;
    rd(ex(3'h0, 9'h0C6));
  endtask
  task automatic report_and_stop;
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Reset for 16 cycles, then every scenario in turn.
  initial begin
    cyc(16);
    nrst = 1'h1;
    cyc(2);
    rx_enable_bit = 1'h1;
    cyc(2);
    chk("owned", 13'(rx_pin_owned), 13'h1);
    t_basic;
    t_sizes;
    t_parity;
    t_frame;
    t_overrun;
    t_flush;
    t_noise;
    t_sync;
    report_and_stop;
  end
  // Cuts a hang short well after the scenarios should have ended.
  initial begin
    cyc(40000);
    error_cnt++;
    report_and_stop;
  end
endmodule
